//--- hdl/cpg_pkg.sv
package cpg_pkg;

  // Register byte offsets.
  localparam logic [7:0] CPG_OFS_PAIR_CTRL   = 8'h00;
  localparam logic [7:0] CPG_OFS_UPPER_MODE  = 8'h04;
  localparam logic [7:0] CPG_OFS_LOWER_MODE  = 8'h08;
  localparam logic [7:0] CPG_OFS_PERIOD_LO   = 8'h0C;
  localparam logic [7:0] CPG_OFS_PERIOD_HI   = 8'h10;
  localparam logic [7:0] CPG_OFS_DUTY_LO     = 8'h14;
  localparam logic [7:0] CPG_OFS_DUTY_HI     = 8'h18;
  localparam logic [7:0] CPG_OFS_SYS_CTRL    = 8'h1C;
  localparam logic [7:0] CPG_OFS_STATUS      = 8'h20;

  // Field positions in timer_pair_control.
  localparam int CPG_BIT_LOWER_RUN = 0;
  localparam int CPG_BIT_UPPER_RUN = 1;
  localparam int CPG_BIT_CASCADE   = 2;

  // Field positions in upper_timer_mode_reg.
  localparam int CPG_POS_TCK       = 0;
  localparam int CPG_BIT_EXT_CLK   = 3;
  localparam int CPG_POS_MODE      = 4;
  localparam int CPG_BIT_INIT_LVL  = 6;
  localparam int CPG_BIT_DBUF      = 7;

  // Field positions in system_control_one.
  localparam int CPG_BIT_DIV_OPT   = 0;
  localparam int CPG_BIT_SLOW      = 1;

  // Field positions in the status word.
  localparam int CPG_POS_COUNT     = 0;
  localparam int CPG_BIT_PIN       = 16;
  localparam int CPG_BIT_RUNNING   = 17;
  localparam int CPG_BIT_PENDING   = 18;

  // Reset values.
  localparam logic [7:0]  CPG_RST_BYTE  = 8'h00;
  localparam logic [15:0] CPG_RST_WORD  = 16'h0000;

  // Mode code that selects the 16-bit pulse generator.
  localparam logic [1:0] CPG_MODE_PPG = 2'h3;

  // Source clock codes with special meaning.
  localparam logic [2:0] CPG_TCK_000 = 3'h0;
  localparam logic [2:0] CPG_TCK_001 = 3'h1;
  localparam logic [2:0] CPG_TCK_111 = 3'h7;

  // Gear clock divider masks for codes 000 to 111: 2^11,2^10,2^8,2^6,2^4,2^2,2,1.
  localparam int CPG_PRE_W = 11;
  localparam logic [CPG_PRE_W-1:0] CPG_GEAR_MASK [8] = '{
    11'h7FF, 11'h3FF, 11'h0FF, 11'h03F, 11'h00F, 11'h003, 11'h001, 11'h000
  };

  // Low-frequency clock divider masks: /2^4, /2^3, /2^2.
  localparam logic [3:0] CPG_FS_MASK_16 = 4'hF;
  localparam logic [3:0] CPG_FS_MASK_8  = 4'h7;
  localparam logic [3:0] CPG_FS_MASK_4  = 4'h3;

  // AHB-Lite encodings.
  localparam logic [1:0] CPG_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CPG_HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } cpg_ahb_req_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
  } cpg_cmp_t;

endpackage

//--- hdl/cpg_top.sv
// Overview of operation
// - Cascade bit joins both timers; only upper timer settings then count.
// - Upper mode field code 11 selects the 16-bit pulse generator.
// - External select 0 counts a prescaled internal clock chosen by 3-bit code.
// - Codes pick gear /2^11..1; divider option (codes 000, 001) or slow mode (000, 001, 111) use low clock.
// - Period and duty are 16 bits, each an upper and lower byte.
// - Write three bytes first; upper duty write commits all four together.
// - Initial-level bit sets idle pin level, driven while stopped.
// - Run bit set makes the 16-bit up counter count source clocks.
// - Count equal duty inverts pin and raises duty-match interrupt.
// - Count equal period restores pin, raises period interrupt, clears count.
// - Clearing run stops, clears counter and returns pin to idle level.
// - Double-buffer select bit at 1 enables the double buffer.
// - Buffered running: new values wait, go active on period match.
// - Buffered stopped: commit loads buffer and active values at once.
// - Unbuffered: commit loads active values at once, running or stopped.
// - Unbuffered value below count matches only after counter wraps.
// - Unbuffered value equal to count matches right after the write.
// - Reading period or duty returns last written value, not active one.
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module cpg_top (
  // Clock and reset.
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave.
  input  wire cpg_pkg::cpg_ahb_req_t ahb_req,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  // Pins.
  input  wire logic              ext_clock_pin,
  input  wire logic              low_freq_clk,
  output var  logic              pulse_output_pin,
  // Interrupt requests.
  output var  logic              duty_match_irq,
  output var  logic              period_match_irq
);
  import cpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic                 wr_pend;
    logic [7:0]           wr_ofs;
    logic [31:0]          rdata;
    logic                 ready;
    logic [7:0]           pair_ctrl;
    logic [7:0]           upper_mode;
    logic [7:0]           lower_mode;
    logic [7:0]           sys_ctrl;
    logic [7:0]           period_lo;
    logic [7:0]           period_hi;
    logic [7:0]           duty_lo;
    logic [7:0]           duty_hi;
    cpg_cmp_t             buffered;
    cpg_cmp_t             active;
    logic                 load_pend;
    logic [CPG_PRE_W-1:0] pre;
    logic [3:0]           fs_div;
    logic [2:0]           ext_sync;
    logic [2:0]           fs_sync;
    logic [15:0]          count;
    logic                 running;
    logic                 pin;
    logic                 duty_irq;
    logic                 period_irq;
  } cpg_state_t;

  cpg_state_t st;
  cpg_state_t next_st;

  logic              enabled;
  logic              ext_edge;
  logic              fs_edge;
  logic              src_tick;
  logic              commit;
  logic              immediate;
  logic              init_lvl;
  logic [2:0]        tck;
  logic [15:0]       next_count;
  logic [15:0]       cmp_count;
  logic              cmp_en;
  cpg_cmp_t          written;
  cpg_cmp_t          cmp;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational update.

  always_comb begin
    next_st = st;

    // Only upper timer fields take part; lower_mode is stored and ignored.
    enabled  = st.pair_ctrl[CPG_BIT_CASCADE] &&
               (st.upper_mode[CPG_POS_MODE +: 2] == CPG_MODE_PPG);
    init_lvl = st.upper_mode[CPG_BIT_INIT_LVL];
    tck      = st.upper_mode[CPG_POS_TCK +: 3];

    // Synchronisers: only stage 1 and 2 are read by logic.
    next_st.ext_sync = {st.ext_sync[1:0], ext_clock_pin};
    next_st.fs_sync  = {st.fs_sync[1:0], low_freq_clk};
    ext_edge = st.ext_sync[1] && !st.ext_sync[2];
    fs_edge  = st.fs_sync[1] && !st.fs_sync[2];

    // The dividers run freely so the first source tick after a start may
    // come early; a gated divider would cost one more enable per code.
    next_st.pre = st.pre + 1'b1;
    if (fs_edge) begin
      next_st.fs_div = st.fs_div + 1'b1;
    end

    // Source clock selection.
    src_tick = 1'b0;
    if (st.upper_mode[CPG_BIT_EXT_CLK]) begin
      src_tick = ext_edge;
    end else if (st.sys_ctrl[CPG_BIT_SLOW]) begin
      case (tck)
        CPG_TCK_000: src_tick = fs_edge && (st.fs_div == CPG_FS_MASK_16);
        CPG_TCK_001: src_tick = fs_edge && ((st.fs_div & CPG_FS_MASK_8) == CPG_FS_MASK_8);
        CPG_TCK_111: src_tick = fs_edge && ((st.fs_div & CPG_FS_MASK_4) == CPG_FS_MASK_4);
        default:     src_tick = 1'b0;
      endcase
    end else if (st.sys_ctrl[CPG_BIT_DIV_OPT] && (tck == CPG_TCK_000)) begin
      src_tick = fs_edge && (st.fs_div == CPG_FS_MASK_16);
    end else if (st.sys_ctrl[CPG_BIT_DIV_OPT] && (tck == CPG_TCK_001)) begin
      src_tick = fs_edge && ((st.fs_div & CPG_FS_MASK_8) == CPG_FS_MASK_8);
    end else begin
      src_tick = (st.pre & CPG_GEAR_MASK[tck]) == CPG_GEAR_MASK[tck];
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus data phase: writes land here.

    commit = 1'b0;
    next_st.ready = 1'b1;
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      case (st.wr_ofs)
        CPG_OFS_PAIR_CTRL:  next_st.pair_ctrl  = ahb_req.hwdata[7:0];
        CPG_OFS_UPPER_MODE: next_st.upper_mode = ahb_req.hwdata[7:0];
        CPG_OFS_LOWER_MODE: next_st.lower_mode = ahb_req.hwdata[7:0];
        CPG_OFS_SYS_CTRL:   next_st.sys_ctrl   = ahb_req.hwdata[7:0];
        CPG_OFS_PERIOD_LO:  next_st.period_lo  = ahb_req.hwdata[7:0];
        CPG_OFS_PERIOD_HI:  next_st.period_hi  = ahb_req.hwdata[7:0];
        CPG_OFS_DUTY_LO:    next_st.duty_lo    = ahb_req.hwdata[7:0];
        CPG_OFS_DUTY_HI: begin
          next_st.duty_hi = ahb_req.hwdata[7:0];
          commit = 1'b1;
        end
        default: begin
        end
      endcase
    end
    written.period = {st.period_hi, st.period_lo};
    written.duty   = {next_st.duty_hi, st.duty_lo};

    //////////////////////////////////////////////////////////////////////////
    // Commit of the four bytes.

    immediate = 1'b0;
    if (commit) begin
      next_st.buffered = written;
      if (!st.upper_mode[CPG_BIT_DBUF] || !st.running) begin
        next_st.active = written;
        next_st.load_pend = 1'b0;
        immediate = st.running && !st.upper_mode[CPG_BIT_DBUF];
      end else begin
        next_st.load_pend = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Counter and pin.

    next_st.duty_irq   = 1'b0;
    next_st.period_irq = 1'b0;
    next_count = st.count + 1'b1;
    cmp        = next_st.active;
    cmp_count  = next_count;
    cmp_en     = 1'b0;
    next_st.running = enabled && st.pair_ctrl[CPG_BIT_UPPER_RUN];

    if (!enabled || !st.pair_ctrl[CPG_BIT_UPPER_RUN]) begin
      next_st.count = CPG_RST_WORD;
      next_st.pin   = init_lvl;
    end else if (src_tick) begin
      next_st.count = next_count;
      cmp_en = 1'b1;
    end else if (immediate) begin
      // A new value equal to the held count matches at once, off the tick.
      cmp_count = st.count;
      cmp_en = 1'b1;
    end

    // Values below the count match only after the wrap, by plain equality.
    if (cmp_en) begin
      if (cmp_count == cmp.period) begin
        next_st.count      = CPG_RST_WORD;
        next_st.pin        = init_lvl;
        next_st.period_irq = 1'b1;
        if (st.load_pend || (commit && st.upper_mode[CPG_BIT_DBUF])) begin
          next_st.active    = next_st.buffered;
          next_st.load_pend = 1'b0;
        end
      end else if (cmp_count == cmp.duty) begin
        next_st.pin      = !st.pin;
        next_st.duty_irq = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus address phase.

    next_st.rdata = 32'h0000_0000;
    if (ahb_req.hsel && ahb_req.hready &&
        ((ahb_req.htrans == CPG_HTRANS_NONSEQ) || (ahb_req.htrans == CPG_HTRANS_SEQ))) begin
      if (ahb_req.hwrite) begin
        next_st.wr_pend = 1'b1;
        next_st.wr_ofs  = ahb_req.haddr[7:0];
      end else begin
        case (ahb_req.haddr[7:0])
          CPG_OFS_PAIR_CTRL:  next_st.rdata[7:0] = st.pair_ctrl;
          CPG_OFS_UPPER_MODE: next_st.rdata[7:0] = st.upper_mode;
          CPG_OFS_LOWER_MODE: next_st.rdata[7:0] = st.lower_mode;
          CPG_OFS_SYS_CTRL:   next_st.rdata[7:0] = st.sys_ctrl;
          CPG_OFS_PERIOD_LO:  next_st.rdata[7:0] = next_st.period_lo;
          CPG_OFS_PERIOD_HI:  next_st.rdata[7:0] = next_st.period_hi;
          CPG_OFS_DUTY_LO:    next_st.rdata[7:0] = next_st.duty_lo;
          CPG_OFS_DUTY_HI:    next_st.rdata[7:0] = next_st.duty_hi;
          CPG_OFS_STATUS: begin
            next_st.rdata[CPG_POS_COUNT +: 16] = st.count;
            next_st.rdata[CPG_BIT_PIN]         = st.pin;
            next_st.rdata[CPG_BIT_RUNNING]     = st.running;
            next_st.rdata[CPG_BIT_PENDING]     = st.load_pend;
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout        = st.ready;
  assign hresp            = 1'b0;
  assign hrdata           = st.rdata;
  assign pulse_output_pin = st.pin;
  assign duty_match_irq   = st.duty_irq;
  assign period_match_irq = st.period_irq;

endmodule

`default_nettype wire

//--- test/cpg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_top_asserts (
  // Clock and reset.
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Register bus.
  input wire cpg_pkg::cpg_ahb_req_t ahb_req,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  // Pins and interrupts.
  input wire logic                  ext_clock_pin,
  input wire logic                  low_freq_clk,
  input wire logic                  pulse_output_pin,
  input wire logic                  duty_match_irq,
  input wire logic                  period_match_irq
);
  import cpg_pkg::*;
  logic       take;
  logic       wv;
  logic       init_lvl;
  logic       run_q;
  logic [7:0] wa;
  logic [2:0] quiet;
  assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  // Shadow of the control bytes, so the idle level is known without peeking inside.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wv, wa, init_lvl, run_q, quiet} <= '0;
    end else begin
      wv <= take && ahb_req.hwrite;
      wa <= ahb_req.haddr[7:0];
      if (wv && wa == CPG_OFS_UPPER_MODE) init_lvl <= ahb_req.hwdata[CPG_BIT_INIT_LVL];
      if (wv && wa == CPG_OFS_PAIR_CTRL) run_q <= ahb_req.hwdata[1] && ahb_req.hwdata[2];
      if (wv && (wa == CPG_OFS_PAIR_CTRL || wa == CPG_OFS_UPPER_MODE)) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_duty_hit;
    duty_match_irq && !period_match_irq;
  endsequence
  sequence s_idle_run;
    quiet >= 3'h4 && !run_q;
  endsequence
  a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("bus stalled");
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_rdata_idle: assert property (!$past(take && !ahb_req.hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_duty_pulse: assert property (duty_match_irq |=> !duty_match_irq)
    else $error("duty irq too long");
  a_period_pulse: assert property (period_match_irq |=> !period_match_irq)
    else $error("period irq too long");
  a_duty_level: assert property (s_duty_hit |-> pulse_output_pin != init_lvl)
    else $error("pin not inverted on duty match");
  a_period_level: assert property (period_match_irq |-> pulse_output_pin == init_lvl)
    else $error("pin not restored on period match");
  a_stop_idle: assert property (s_idle_run |-> pulse_output_pin == init_lvl
    && !duty_match_irq && !period_match_irq) else $error("stopped timer not idle");
  a_irq_running: assert property ((duty_match_irq || period_match_irq) |->
    run_q || $past(run_q)) else $error("irq while stopped");
endmodule
bind cpg_top cpg_top_asserts cpg_top_asserts_inst (.hclk(hclk), .hresetn(hresetn),
  .ahb_req(ahb_req), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ext_clock_pin(ext_clock_pin), .low_freq_clk(low_freq_clk),
  .pulse_output_pin(pulse_output_pin), .duty_match_irq(duty_match_irq),
  .period_match_irq(period_match_irq));
`default_nettype wire

//--- test/cpg_pulse_load.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_pulse_load (
  // Clock.
  input  wire logic        hclk,
  // Pulse pin and clock request.
  input  wire logic        pulse_output_pin,
  input  wire logic        ext_en,
  // Source clock and measured pulse.
  output var  logic        ext_clock_pin,
  output var  logic [15:0] hi_len,
  output var  logic [15:0] per_len
);
  logic        prev;
  logic [1:0]  div;
  logic [15:0] run;
  logic [15:0] hi;
  initial {prev, div, run, hi, ext_clock_pin, hi_len, per_len} = '0;
  // Each level lasts four cycles, twice the minimum; the clock rests low when unused.
  always @(posedge hclk) begin
    div <= div + 2'h1;
    if (!ext_en) ext_clock_pin <= 1'b0;
    else if (div == 2'h3) ext_clock_pin <= !ext_clock_pin;
    prev <= pulse_output_pin;
    run <= run + 16'h1;
    if (pulse_output_pin && !prev) begin
      per_len <= run;
      run <= 16'h1;
      hi <= 16'h1;
    end else if (pulse_output_pin) begin
      hi <= hi + 16'h1;
    end
    if (!pulse_output_pin && prev) hi_len <= hi;
  end
endmodule
`default_nettype wire

//--- test/cascaded_16bit_pulse_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module cascaded_16bit_pulse_generator_test;
  import cpg_pkg::*;
  logic         hclk, hresetn, low_freq_clk, ext_en, ext_clock_pin;
  logic         hreadyout, hresp, pin, dirq, pirq;
  logic [31:0]  hrdata, q;
  logic [15:0]  hi_len, per_len;
  cpg_ahb_req_t req, bus;
  int           fails, checked, cyc;
  logic [1:0]   tsys [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
  logic [2:0]   tcode [7] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h0, 3'h1, 3'h7};
  int           tdiv [7] = '{1, 2, 4, 16, 256, 128, 64};
  always #10 hclk = !hclk;
  always #160 low_freq_clk = !low_freq_clk;
  always_comb begin
    bus = req;
    bus.hready = hreadyout;
  end
  cpg_top cpg_top_inst (.hclk(hclk), .hresetn(hresetn), .ahb_req(bus),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clock_pin(ext_clock_pin),
    .low_freq_clk(low_freq_clk), .pulse_output_pin(pin), .duty_match_irq(dirq),
    .period_match_irq(pirq));
  cpg_pulse_load cpg_pulse_load_inst (.hclk(hclk), .pulse_output_pin(pin), .ext_en(ext_en),
    .ext_clock_pin(ext_clock_pin), .hi_len(hi_len), .per_len(per_len));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    req.hsel <= 1'b1;
    req.haddr <= {24'h0, a};
    req.htrans <= CPG_HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  task cfg(input logic [15:0] p, input logic [15:0] d);
    wr(CPG_OFS_PERIOD_LO, p[7:0]);
    wr(CPG_OFS_PERIOD_HI, p[15:8]);
    wr(CPG_OFS_DUTY_LO, d[7:0]);
    wr(CPG_OFS_DUTY_HI, d[15:8]);
  endtask
  // The period ending at the third rising edge is judged, so a short first prescaler tick cannot skew it.
  task meas(input logic [15:0] h, input logic [15:0] p);
    repeat (3) @(posedge pin);
    @(negedge pin);
    repeat (2) @(posedge hclk);
    chk({16'h0, per_len}, {16'h0, p});
    chk({16'h0, hi_len}, {16'h0, h});
  endtask
  task settle;
    repeat (4) @(posedge hclk);
  endtask
  task results;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      results;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {hclk, hresetn, low_freq_clk, ext_en, req, fails, checked, cyc} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(CPG_OFS_LOWER_MODE, 8'hFF);
    wr(CPG_OFS_PAIR_CTRL, 8'h04);
    wr(CPG_OFS_UPPER_MODE, 8'h77);
    settle;
    chk({31'h0, pin}, 32'h1);
    wr(CPG_OFS_UPPER_MODE, 8'h37);
    cfg(16'h0010, 16'h0006);
    rd(CPG_OFS_DUTY_LO, 32'hFFFFFFFF, 32'h6);
    rd(CPG_OFS_PERIOD_LO, 32'hFFFFFFFF, 32'h10);
    rd(8'h30, 32'hFFFFFFFF, 32'h0);
    $display("registers done");
    wr(CPG_OFS_PAIR_CTRL, 8'h06);
    meas(16'd10, 16'd16);
    cfg(16'h0010, 16'h0002);
    meas(16'd14, 16'd16);
    wr(CPG_OFS_PAIR_CTRL, 8'h04);
    settle;
    rd(CPG_OFS_STATUS, 32'h0003FFFF, 32'h0);
    $display("unbuffered done");
    wr(CPG_OFS_UPPER_MODE, 8'h27);
    wr(CPG_OFS_PAIR_CTRL, 8'h06);
    settle;
    rd(CPG_OFS_STATUS, 32'h0001FFFF, 32'h0);
    wr(CPG_OFS_PAIR_CTRL, 8'h04);
    $display("mode select done");
    wr(CPG_OFS_UPPER_MODE, 8'hB7);
    cfg(16'h0100, 16'h0080);
    wr(CPG_OFS_PAIR_CTRL, 8'h06);
    meas(16'h0080, 16'h0100);
    cfg(16'h0020, 16'h000C);
    rd(CPG_OFS_STATUS, 32'h00040000, 32'h00040000);
    rd(CPG_OFS_PERIOD_LO, 32'hFFFFFFFF, 32'h20);
    meas(16'h0014, 16'h0020);
    $display("buffered done");
    wr(CPG_OFS_PAIR_CTRL, 8'h04);
    cfg(16'h0004, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      wr(CPG_OFS_PAIR_CTRL, 8'h04);
      wr(CPG_OFS_SYS_CTRL, {6'h0, tsys[i]});
      wr(CPG_OFS_UPPER_MODE, {5'h06, tcode[i]});
      wr(CPG_OFS_PAIR_CTRL, 8'h06);
      meas(16'(2 * tdiv[i]), 16'(4 * tdiv[i]));
    end
    $display("clock select done");
    wr(CPG_OFS_PAIR_CTRL, 8'h04);
    wr(CPG_OFS_SYS_CTRL, 8'h00);
    wr(CPG_OFS_UPPER_MODE, 8'h3F);
    ext_en <= 1'b1;
    wr(CPG_OFS_PAIR_CTRL, 8'h06);
    meas(16'd16, 16'd32);
    $display("external clock done");
    results;
  end
endmodule
`default_nettype wire
